// [pwmoc_consts.vh]
// Register offsets, field positions and codes of the PWM output-control slice
`ifndef PWMOC_CONSTS_VH
`define PWMOC_CONSTS_VH

// Register byte offsets
`define PWMOC_OFS_STATUS 5'h00
`define PWMOC_OFS_IOCONL 5'h04
`define PWMOC_OFS_IOCONH 5'h08
`define PWMOC_OFS_SNAP 5'h0C
`define PWMOC_OFS_CTRL 5'h10

// Status field positions
`define PWMOC_ST_SNAP 5
`define PWMOC_ST_PEND 4
`define PWMOC_ST_REQ 3
`define PWMOC_ST_PHASE 2
`define PWMOC_ST_HALF 1
`define PWMOC_ST_ACTIVE 0

// Output-control-low field positions
`define PWMOC_L_CLMODE 15
`define PWMOC_L_SWAP 14
`define PWMOC_L_FENH 13
`define PWMOC_L_FENL 12
`define PWMOC_L_FDAT_HI 11
`define PWMOC_L_FDAT_LO 10
`define PWMOC_L_FSYNC_HI 9
`define PWMOC_L_FSYNC_LO 8

// Output-control-high field positions
`define PWMOC_H_SRC_HI 14
`define PWMOC_H_SRC_LO 12
`define PWMOC_H_DTC 8
`define PWMOC_H_MODE_HI 5
`define PWMOC_H_MODE_LO 4
`define PWMOC_H_OWNH 3
`define PWMOC_H_OWNL 2
`define PWMOC_H_INVH 1
`define PWMOC_H_INVL 0

// Writable masks and reset values
`define PWMOC_IOCONH_MASK 16'h713F
`define PWMOC_IOCONL_RST 16'h0000
`define PWMOC_IOCONH_RST 16'h0000
`define PWMOC_MODE_RST 3'h0

// Force timing codes
`define PWMOC_FS_SOC 2'h0
`define PWMOC_FS_NOW 2'h1
`define PWMOC_FS_XFER 2'h2

// Pair output modes
`define PWMOC_PM_COMP 2'h0
`define PWMOC_PM_INDEP 2'h1
`define PWMOC_PM_PUSH 2'h2

// Snapshot sources
`define PWMOC_SS_SW 3'h0
`define PWMOC_SS_SYNC 3'h1
`define PWMOC_SS_FF 3'h2
`define PWMOC_SS_LIM 3'h3
`define PWMOC_SS_FAULT 3'h4

// Buffer transfer modes
`define PWMOC_BT_SOC 3'h0
`define PWMOC_BT_NOW 3'h1
`define PWMOC_BT_HSOC 3'h2
`define PWMOC_BT_HNOW 3'h3

`endif

// [pwmoc_top.v]
// PWM generator output control, status and time base snapshot with Avalon-MM slave
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`include "pwmoc_consts.vh"

module pwmoc_top (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire [4:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	input wire [15:0] TB_COUNT,
	input wire GEN_H,
	input wire GEN_L,
	input wire SOC,
	input wire CYCLE_RUN,
	input wire PP_PHASE,
	input wire CA_HALF,
	input wire HOST_UPD,
	input wire FAULT_ACT,
	input wire LIMIT_ACT,
	input wire FF_ACT,
	input wire SYNC_ACT,
	input wire DBG_HALT,
	output reg HIGH_SIDE_OUTPUT_O,
	output reg HIGH_SIDE_OUTPUT_OE,
	output reg LOW_SIDE_OUTPUT_O,
	output reg LOW_SIDE_OUTPUT_OE,
	output reg DTC_CTRL,
	output reg BUF_XFER,
	output reg DATA_WR_LOCK
);

	// ==========================================================
	// Declarations
	reg wait_q;
	reg [15:0] ioconl_q;
	reg [15:0] ioconh_q;
	reg [2:0] xfer_mode_q;
	reg [15:0] snap_q;
	reg snap_flag_q;
	reg pend_q;
	reg [3:0] force_act_q;
	reg [3:0] act_prev_q;
	reg [31:0] rdata_d;
	reg pend_d;
	reg xfer_now;
	reg src_edge;
	reg [1:0] pair;
	reg [1:0] pins;
	reg [1:0] ftime;
	reg [1:0] pmode;
	reg [2:0] ssrc;
	reg force_load;
	wire wr_en;
	wire lo_be;
	wire hi_be;
	wire [3:0] act_now;
	wire [3:0] act_rise;
	wire sw_snap;
	wire snap_take;
	wire snap_clr;
	wire req_set;
	wire [15:0] wmask;
	wire [15:0] wdat;

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then answer
	assign wr_en = AVS_WRITE & ~wait_q;
	assign lo_be = AVS_BYTEENABLE[0];
	assign hi_be = AVS_BYTEENABLE[1];
	assign wmask = {{8{hi_be}}, {8{lo_be}}};
	assign wdat = AVS_WRITEDATA[15:0] & wmask;

	// Wait request drops one cycle after the request rises
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			wait_q <= 1'b1;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			wait_q <= ~((AVS_READ | AVS_WRITE) & wait_q);
			AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & wait_q);
		end
	end

	// Read mux; unmapped offsets read zero
	always @* begin
		rdata_d = 32'h00000000;
		case (AVS_ADDRESS)
			`PWMOC_OFS_STATUS: begin
				rdata_d[11:8] = {SYNC_ACT, FAULT_ACT, LIMIT_ACT, FF_ACT};
				rdata_d[`PWMOC_ST_SNAP] = snap_flag_q;
				rdata_d[`PWMOC_ST_PEND] = pend_q;
				rdata_d[`PWMOC_ST_REQ] = 1'b0;
				rdata_d[`PWMOC_ST_PHASE] = (pmode == `PWMOC_PM_PUSH) & PP_PHASE;
				rdata_d[`PWMOC_ST_HALF] = CA_HALF;
				rdata_d[`PWMOC_ST_ACTIVE] = CYCLE_RUN;
			end
			`PWMOC_OFS_IOCONL: begin
				rdata_d[15:0] = ioconl_q;
			end
			`PWMOC_OFS_IOCONH: begin
				rdata_d[15:0] = ioconh_q;
			end
			`PWMOC_OFS_SNAP: begin
				rdata_d[15:0] = snap_q;
			end
			`PWMOC_OFS_CTRL: begin
				rdata_d[2:0] = xfer_mode_q;
			end
			default: begin
				rdata_d = 32'h00000000;
			end
		endcase
	end

	// Read data loaded as wait request drops
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			AVS_READDATA <= 32'h00000000;
		end else if ((AVS_READ | AVS_WRITE) & wait_q) begin
			AVS_READDATA <= AVS_READ ? rdata_d : 32'h00000000;
		end
	end

	// ==========================================================
	// Control registers
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ioconl_q <= `PWMOC_IOCONL_RST;
			ioconh_q <= `PWMOC_IOCONH_RST;
			xfer_mode_q <= `PWMOC_MODE_RST;
		end else if (wr_en) begin
			case (AVS_ADDRESS)
				`PWMOC_OFS_IOCONL: begin
					ioconl_q <= (ioconl_q & ~wmask) | wdat;
				end
				`PWMOC_OFS_IOCONH: begin
					ioconh_q <= (ioconh_q & ~wmask) | (wdat & `PWMOC_IOCONH_MASK);
				end
				`PWMOC_OFS_CTRL: begin
					if (lo_be) begin
						xfer_mode_q <= AVS_WRITEDATA[2:0];
					end
				end
				default: begin
					xfer_mode_q <= xfer_mode_q;
				end
			endcase
		end
	end

	// ==========================================================
	// Buffer transfer request and pending flag
	assign req_set = wr_en & lo_be & (AVS_ADDRESS == `PWMOC_OFS_STATUS) &
		AVS_WRITEDATA[`PWMOC_ST_REQ];

	// Transfer moment per mode; host modes also wait for HOST_UPD before the transfer
	always @* begin
		xfer_now = 1'b0;
		pend_d = pend_q;
		case (xfer_mode_q)
			`PWMOC_BT_SOC: begin
				xfer_now = pend_q & SOC;
			end
			`PWMOC_BT_NOW: begin
				xfer_now = pend_q;
			end
			`PWMOC_BT_HSOC: begin
				xfer_now = pend_q & HOST_UPD & SOC;
			end
			`PWMOC_BT_HNOW: begin
				xfer_now = pend_q & HOST_UPD;
			end
			default: begin
				xfer_now = pend_q & SOC;
			end
		endcase
		if (xfer_now) begin
			pend_d = 1'b0;
		end
		if (req_set) begin
			pend_d = 1'b1;
		end
	end

	// Pending register and data lock
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			pend_q <= 1'b0;
			BUF_XFER <= 1'b0;
			DATA_WR_LOCK <= 1'b0;
		end else begin
			pend_q <= pend_d;
			BUF_XFER <= xfer_now;
			DATA_WR_LOCK <= pend_d;
		end
	end

	// ==========================================================
	// Time base snapshot
	assign act_now = {FAULT_ACT, LIMIT_ACT, FF_ACT, SYNC_ACT};
	assign act_rise = act_now & ~act_prev_q;
	assign sw_snap = wr_en & lo_be & (AVS_ADDRESS == `PWMOC_OFS_SNAP) & AVS_WRITEDATA[0];
	assign snap_clr = wr_en & lo_be & (AVS_ADDRESS == `PWMOC_OFS_STATUS) &
		AVS_WRITEDATA[`PWMOC_ST_SNAP];
	assign snap_take = (sw_snap | src_edge) & (~snap_flag_q | snap_clr);

	// Selected hardware source edge
	always @* begin
		ssrc = ioconh_q[`PWMOC_H_SRC_HI:`PWMOC_H_SRC_LO];
		case (ssrc)
			`PWMOC_SS_SYNC: begin
				src_edge = act_rise[0];
			end
			`PWMOC_SS_FF: begin
				src_edge = act_rise[1];
			end
			`PWMOC_SS_LIM: begin
				src_edge = act_rise[2];
			end
			`PWMOC_SS_FAULT: begin
				src_edge = act_rise[3];
			end
			default: begin
				src_edge = 1'b0;
			end
		endcase
	end

	// Snapshot value and flag; a new snapshot beats the clear
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			act_prev_q <= 4'h0;
			snap_q <= 16'h0000;
			snap_flag_q <= 1'b0;
		end else begin
			act_prev_q <= act_now;
			if (snap_take) begin
				snap_q <= TB_COUNT;
				snap_flag_q <= 1'b1;
			end else if (snap_clr) begin
				snap_flag_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Force (override) field takes effect per timing select
	always @* begin
		ftime = ioconl_q[`PWMOC_L_FSYNC_HI:`PWMOC_L_FSYNC_LO];
		case (ftime)
			`PWMOC_FS_NOW: begin
				force_load = 1'b1;
			end
			`PWMOC_FS_XFER: begin
				force_load = xfer_now;
			end
			default: begin
				force_load = SOC;
			end
		endcase
	end

	// Active force bits: {high enable, low enable, high level, low level}
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			force_act_q <= 4'h0;
		end else if (force_load) begin
			force_act_q <= ioconl_q[`PWMOC_L_FENH:`PWMOC_L_FDAT_LO];
		end
	end

	// ==========================================================
	// Output path: mode, swap, priority, polarity, ownership
	always @* begin
		pmode = ioconh_q[`PWMOC_H_MODE_HI:`PWMOC_H_MODE_LO];
		case (pmode)
			`PWMOC_PM_INDEP: begin
				pair = {GEN_H, GEN_L};
			end
			`PWMOC_PM_PUSH: begin
				pair = {GEN_H & ~PP_PHASE, GEN_H & PP_PHASE};
			end
			default: begin
				pair = {GEN_H, ~GEN_H};
			end
		endcase
		if (ioconl_q[`PWMOC_L_SWAP]) begin
			pair = {pair[0], pair[1]};
		end
		pins = pair;
		if (force_act_q[3]) begin
			pins[1] = force_act_q[1];
		end
		if (force_act_q[2]) begin
			pins[0] = force_act_q[0];
		end
		// Highest priority last so it wins
		if (FF_ACT) begin
			pins = ioconl_q[3:2];
		end
		if (LIMIT_ACT) begin
			pins = ioconl_q[`PWMOC_L_CLMODE] ? ~pair : ioconl_q[5:4];
		end
		if (FAULT_ACT) begin
			pins = ioconl_q[7:6];
		end
		if (DBG_HALT) begin
			pins = ioconl_q[1:0];
		end
	end

	// Registered pins; a released pin drives low with enable off
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			HIGH_SIDE_OUTPUT_O <= 1'b0;
			HIGH_SIDE_OUTPUT_OE <= 1'b0;
			LOW_SIDE_OUTPUT_O <= 1'b0;
			LOW_SIDE_OUTPUT_OE <= 1'b0;
			DTC_CTRL <= 1'b0;
		end else begin
			HIGH_SIDE_OUTPUT_OE <= ioconh_q[`PWMOC_H_OWNH];
			LOW_SIDE_OUTPUT_OE <= ioconh_q[`PWMOC_H_OWNL];
			HIGH_SIDE_OUTPUT_O <= ioconh_q[`PWMOC_H_OWNH] &
				(pins[1] ^ ioconh_q[`PWMOC_H_INVH]);
			LOW_SIDE_OUTPUT_O <= ioconh_q[`PWMOC_H_OWNL] &
				(pins[0] ^ ioconh_q[`PWMOC_H_INVL]);
			DTC_CTRL <= ioconh_q[`PWMOC_H_DTC] ? FF_ACT : SYNC_ACT;
		end
	end

endmodule

// [pwmoc_asserts.sv]
// Checker for the PWM output-control slice at its top ports
module pwmoc_asserts (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire [4:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	input wire [31:0] AVS_READDATA,
	input wire AVS_WAITREQUEST,
	input wire FF_ACT,
	input wire SYNC_ACT,
	input wire HIGH_SIDE_OUTPUT_O,
	input wire HIGH_SIDE_OUTPUT_OE,
	input wire LOW_SIDE_OUTPUT_O,
	input wire LOW_SIDE_OUTPUT_OE,
	input wire DTC_CTRL,
	input wire BUF_XFER,
	input wire DATA_WR_LOCK
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	// ===========================================
	// Bus, pending, pins and compensation
	bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("waitrequest did not drop");
	bus_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	rd_upper_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
		else $error("upper read data set");
	rd_unmapped_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 5'h10
		|-> AVS_READDATA == 32'h0000_0000) else $error("unmapped read not zero");
	req_pending_a: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00 &&
		AVS_WRITEDATA[3] && AVS_BYTEENABLE[0] |=> DATA_WR_LOCK) else $error("request not pending");
	xfer_pulse_a: assert property (BUF_XFER |=> !BUF_XFER) else $error("transfer pulse too long");
	dtc_source_a: assert property (DTC_CTRL |-> $past(FF_ACT) || $past(SYNC_ACT))
		else $error("compensation without source");
	high_release_a: assert property (!HIGH_SIDE_OUTPUT_OE |-> !HIGH_SIDE_OUTPUT_O)
		else $error("high driven while released");
	low_release_a: assert property (!LOW_SIDE_OUTPUT_OE |-> !LOW_SIDE_OUTPUT_O)
		else $error("low driven while released");
	// Main scenarios reached
	cover property (BUF_XFER);
	cover property (DATA_WR_LOCK);
	cover property (DTC_CTRL);
endmodule

bind pwmoc_top pwmoc_asserts chk (.*);

// [pwmoc_stage.sv]
// Power stage driver model on the high and low pins
module pwmoc_stage (
	input wire h_o,
	input wire h_oe,
	input wire l_o,
	input wire l_oe,
	output wire h_pin,
	output wire l_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pin falls to the gate pull-down
	assign h_pin = h_oe ? h_o : 1'b0;
	assign l_pin = l_oe ? l_o : 1'b0;
endmodule

// [test_pwm_output_control_status.sv]
// Self-checking bench for the PWM output-control slice
`include "pwmoc_consts.vh"
module test_pwm_output_control_status;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS = 0, ARST_N = 0, AVS_READ = 0, AVS_WRITE = 0, SOC = 0, HOST_UPD = 0;
	logic [4:0] AVS_ADDRESS = 5'h00;
	logic [31:0] AVS_WRITEDATA = 32'h0, v, w;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [15:0] TB_COUNT = 16'h0;
	logic GEN_H = 0, GEN_L = 0, CYCLE_RUN = 0, PP_PHASE = 0, CA_HALF = 0, look = 0, lr, sh, sl;
	logic FAULT_ACT = 0, LIMIT_ACT = 0, FF_ACT = 0, SYNC_ACT = 0, DBG_HALT = 0;
	logic [1:0] e;
	wire [31:0] AVS_READDATA;
	wire AVS_WAITREQUEST, HIGH_SIDE_OUTPUT_O, HIGH_SIDE_OUTPUT_OE, LOW_SIDE_OUTPUT_O;
	wire LOW_SIDE_OUTPUT_OE, DTC_CTRL, BUF_XFER, DATA_WR_LOCK, h_pin, l_pin;
	int err_count = 0, samples_checked = 0, seed = 75106;
	logic [31:0] rq[$];
	logic [3:0] pq[$];
	logic dq[$];
	pwmoc_top DUT (.*);
	pwmoc_stage stage (.h_o(HIGH_SIDE_OUTPUT_O), .h_oe(HIGH_SIDE_OUTPUT_OE),
		.l_o(LOW_SIDE_OUTPUT_O), .l_oe(LOW_SIDE_OUTPUT_OE), .h_pin(h_pin), .l_pin(l_pin));
	// ===========================================
	// Clock and shared tasks
	always #25 CLK_SYS = ~CLK_SYS;
	task automatic test_done;
		$display("Checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] s);
		samples_checked++;
		if (x !== s) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
		int n = 0;
		@(posedge CLK_SYS);
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		do begin
			@(negedge CLK_SYS);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		if (AVS_WAITREQUEST !== 1'b0) begin
			err_count++;
			test_done();
		end
		@(posedge CLK_SYS);
		AVS_WRITE <= 0;
		AVS_READ <= 0;
	endtask
	task automatic rd(logic [4:0] a, logic [31:0] x);
		rq.push_back(x);
		bus(0, a, 32'h0);
	endtask
	task automatic pin(logic [3:0] x);
		pq.push_back(x);
		repeat (3) @(posedge CLK_SYS);
		look <= 1;
		@(posedge CLK_SYS);
		look <= 0;
	endtask
	task automatic soc;
		SOC <= 1;
		@(posedge CLK_SYS);
		SOC <= 0;
	endtask
	// Watcher pairs each result with the oldest note
	always @(posedge CLK_SYS) begin
		if (AVS_READ && AVS_WAITREQUEST === 1'b0) chk("readdata", rq.pop_front(), AVS_READDATA);
		if (look) chk("pins", pq.pop_front(), {HIGH_SIDE_OUTPUT_OE, h_pin, LOW_SIDE_OUTPUT_OE, l_pin});
		if (look && dq.size() > 0) chk("dtc", dq.pop_front(), DTC_CTRL);
	end
	// ===========================================
	// Main sequence
	initial begin
		repeat (3) @(posedge CLK_SYS);
		ARST_N <= 1;
		rd(`PWMOC_OFS_STATUS, 32'h0);
		rd(`PWMOC_OFS_IOCONL, 32'h0);
		wr_chk: bus(1, `PWMOC_OFS_IOCONH, 32'hFFFF);
		rd(`PWMOC_OFS_IOCONH, 32'h713F);
		rd(5'h14, 32'h0);
		$display("registers done");
		for (int i = 0; i < 24; i++) begin
			v = $random(seed);
			{GEN_H, GEN_L} <= v[1:0];
			bus(1, `PWMOC_OFS_IOCONL, {17'h0, v[2], 14'h0});
			bus(1, `PWMOC_OFS_IOCONH, {25'h0, v[9] & ~v[8], v[8], v[7:4]});
			lr = (v[9] & ~v[8]) ? 1'b0 : v[8] ? v[0] : ~v[1];
			sh = v[2] ? lr : v[1];
			sl = v[2] ? v[1] : lr;
			pin({v[7], v[7] & (sh ^ v[5]), v[6], v[6] & (sl ^ v[4])});
		end
		{GEN_H, GEN_L} <= 2'b00;
		bus(1, `PWMOC_OFS_IOCONH, 32'h010C);
		bus(1, `PWMOC_OFS_IOCONL, 32'h359C);
		for (int j = 0; j < 16; j++) begin
			{DBG_HALT, FAULT_ACT, LIMIT_ACT, FF_ACT} <= j[3:0];
			SYNC_ACT <= j[1];
			e = j[3] ? 2'b00 : j[2] ? 2'b10 : j[1] ? 2'b01 : j[0] ? 2'b11 : 2'b01;
			dq.push_back(j[0]);
			pin({1'b1, e[1], 1'b1, e[0]});
		end
		{DBG_HALT, FAULT_ACT, LIMIT_ACT, FF_ACT, SYNC_ACT} <= 5'h00;
		bus(1, `PWMOC_OFS_IOCONL, 32'h3C9C);
		pin(4'b1011);
		soc();
		pin(4'b1111);
		bus(1, `PWMOC_OFS_IOCONL, 32'h8000);
		{GEN_H, GEN_L, LIMIT_ACT} <= 3'b101;
		pin(4'b1011);
		LIMIT_ACT <= 0;
		$display("pins done");
		v = $random(seed);
		w = $random(seed);
		bus(1, `PWMOC_OFS_IOCONH, 32'h4000);
		{TB_COUNT, CYCLE_RUN, CA_HALF, PP_PHASE} <= {v[15:0], 3'b111};
		FAULT_ACT <= 1;
		rd(`PWMOC_OFS_SNAP, {16'h0, v[15:0]});
		rd(`PWMOC_OFS_STATUS, 32'h0423);
		TB_COUNT <= w[15:0];
		FAULT_ACT <= 0;
		@(posedge CLK_SYS);
		FAULT_ACT <= 1;
		rd(`PWMOC_OFS_SNAP, {16'h0, v[15:0]});
		bus(1, `PWMOC_OFS_STATUS, 32'h0020);
		bus(1, `PWMOC_OFS_SNAP, 32'h0001);
		FAULT_ACT <= 0;
		rd(`PWMOC_OFS_SNAP, {16'h0, w[15:0]});
		bus(1, `PWMOC_OFS_STATUS, 32'h0008);
		rd(`PWMOC_OFS_STATUS, 32'h0033);
		chk("lock", 32'h1, {31'h0, DATA_WR_LOCK});
		soc();
		rd(`PWMOC_OFS_STATUS, 32'h0023);
		chk("lock", 32'h0, {31'h0, DATA_WR_LOCK});
		$display("status done");
		test_done();
	end
endmodule
